//--- pkg/mfb_pkg.sv
/*
  Shared constants and carrier types of the monitor flag bank: byte
  offsets, reset values, flag field positions, threshold and condition
  bundles, and the bank's own state record.
  Assumes the serial management engine that reads the bank, and the
  monitor front end that samples temperature and supply, sit outside.
*/
// What this block does
// - Every flag except byte 6 bit 0 reads zero after reset and while no condition occurred.
// - A defined condition sets its flag bit to one.
// - A set flag stays latched until a read of its byte clears it.
// - The module reset pin clears every latched flag.
// - Flag field sits at byte addresses 3 through 21.
// - Byte 3 low nibble: receive signal loss; high nibble unsupported, zero.
// - Byte 4 low nibble laser faults; high nibble equalizer faults if supported.
// - Byte 5: transmit lock loss high nibble, receive lock loss low nibble.
// - Byte 6 bits 7 to 4: temperature alarms and warnings; 3 to 1 reserved.
// - Byte 6 bit 0 sets after reset completes, clears when read.
// - Byte 7 bits 7 to 4: supply alarms and warnings; rest reserved.
// - Bytes 9 and 10: receive power flags, one nibble per channel.
// - Bytes 11 and 12: transmit bias flags, same nibble layout.
// - Bytes 13 and 14: transmit power flags, same nibble layout.
// - Bytes 15 to 18 reserved, bytes 19 to 21 vendor specific.
// - Measurements are 16 bits, high byte at the lower address.
// - Temperature high byte at 22, low byte at 23.
// - Supply voltage high byte at 26, low byte at 27.
// - Thresholds and measurements share one 16-bit encoding, compared directly.
// - Data-not-ready stays high from power-up until monitor data valid.
// - Flag and monitor bytes are read-only over the serial interface.
package mfb_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W          = 7;
  localparam int unsigned NUM_FLAG_BYTES  = 19;
  localparam logic [6:0]  OFF_FLAG_FIRST  = 7'h03;
  localparam logic [6:0]  OFF_FLAG_LAST   = 7'h15;
  localparam logic [6:0]  OFF_SIGNAL_LOSS = 7'h03;
  localparam logic [6:0]  OFF_TX_FAULT    = 7'h04;
  localparam logic [6:0]  OFF_LOCK_LOSS   = 7'h05;
  localparam logic [6:0]  OFF_TEMP_FLAGS  = 7'h06;
  localparam logic [6:0]  OFF_VCC_FLAGS   = 7'h07;
  localparam logic [6:0]  OFF_RX_POW_CH12 = 7'h09;
  localparam logic [6:0]  OFF_RX_POW_CH34 = 7'h0a;
  localparam logic [6:0]  OFF_BIAS_CH12   = 7'h0b;
  localparam logic [6:0]  OFF_BIAS_CH34   = 7'h0c;
  localparam logic [6:0]  OFF_TX_POW_CH12 = 7'h0d;
  localparam logic [6:0]  OFF_TX_POW_CH34 = 7'h0e;
  localparam logic [6:0]  OFF_TEMP_HIGH   = 7'h16;
  localparam logic [6:0]  OFF_TEMP_LOW    = 7'h17;
  localparam logic [6:0]  OFF_VCC_HIGH    = 7'h1a;
  localparam logic [6:0]  OFF_VCC_LOW     = 7'h1b;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned INIT_DONE_BIT   = 0;
  localparam logic [7:0]  FLAG_RESET      = 8'h00;
  localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;
  localparam logic [15:0] MON_RESET       = 16'h0000;
  localparam logic        NOT_READY_RESET = 1'b1;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] high_alarm;
    logic [15:0] low_alarm;
    logic [15:0] high_warn;
    logic [15:0] low_warn;
  } mfb_thresh_t;

  // Per channel nibble: high alarm, low alarm, high warn, low warn
  typedef struct packed {
    logic [3:0][3:0] rx_power;
    logic [3:0][3:0] tx_bias;
    logic [3:0][3:0] tx_power;
  } mfb_chan_cond_t;

  typedef struct packed {
    logic [3:0] signal_absent;
    logic [3:0] laser_fault;
    logic [3:0] equalizer_fault;
    logic [3:0] tx_lock_lost;
    logic [3:0] rx_lock_lost;
  } mfb_chan_status_t;

  typedef enum logic [1:0] {
    MFB_HOLD_NONE,
    MFB_HOLD_TEMP,
    MFB_HOLD_VCC
  } mfb_hold_t;

  typedef struct packed {
    logic [NUM_FLAG_BYTES-1:0][7:0] flags;
    logic                           init_pending;
    logic                           data_not_ready;
    logic [15:0]                    temp;
    logic [15:0]                    vcc;
    mfb_hold_t                      hold_sel;
    logic [7:0]                     hold_lsb;
    logic [7:0]                     rd_data;
    logic                           rd_valid;
  } mfb_state_t;

endpackage : mfb_pkg

//--- core/mfb_limit_check.sv
/*
  Threshold comparator for one 16-bit monitor value: raises high and
  low alarm and warning conditions.
  Assumes thresholds arrive in the same encoding as the measurement.
*/
module mfb_limit_check #(
  parameter bit SIGNED_VALUE = 1'b0
) (
  input  wire logic                [15:0] value_i,
  input  wire mfb_pkg::mfb_thresh_t       thr_i,
  input  wire logic                       enable_i,
  output logic                     [3:0]  cond_o
);

  // ----------------------------------------------------------------
  // Comparison
  // ----------------------------------------------------------------

  // Temperature is two's complement, supply is plain binary
  function automatic logic above(input logic [15:0] a,
                                 input logic [15:0] b);
    if (SIGNED_VALUE) begin
      return $signed(a) > $signed(b);
    end
    return a > b;
  endfunction : above

  always_comb begin
    cond_o = 4'h0;
    if (enable_i) begin
      cond_o[3] = above(value_i, thr_i.high_alarm);
      cond_o[2] = above(thr_i.low_alarm, value_i);
      cond_o[1] = above(value_i, thr_i.high_warn);
      cond_o[0] = above(thr_i.low_warn, value_i);
    end
  end

endmodule : mfb_limit_check

//--- core/mfb_flag_bank.sv
/*
  Lower-page monitor flag bank: latched channel and module flags,
  initialization flag, and the 16-bit temperature and supply monitors,
  served byte by byte to the serial management engine.
  Assumes all inputs are synchronous to clk_sys_i; the serial engine
  issues one read request per byte and takes the answer a cycle later.
*/
module mfb_flag_bank #(
  parameter bit EQ_FAULT_SUPPORTED = 1'b0
) (
  input  wire logic                          clk_sys_i,
  input  wire logic                          reset_i,
  input  wire logic                          module_reset_n_pin_i,
  input  wire mfb_pkg::mfb_chan_status_t     status_i,
  input  wire mfb_pkg::mfb_chan_cond_t       chan_cond_i,
  input  wire logic                   [15:0] temp_value_i,
  input  wire logic                   [15:0] vcc_value_i,
  input  wire logic                          monitor_valid_i,
  input  wire mfb_pkg::mfb_thresh_t          temp_thr_i,
  input  wire mfb_pkg::mfb_thresh_t          vcc_thr_i,
  input  wire logic                          rd_req_i,
  input  wire logic                   [6:0]  rd_addr_i,
  output logic                        [7:0]  rd_data_o,
  output logic                               rd_valid_o,
  output logic                               data_not_ready_o
);

  // ----------------------------------------------------------------
  // Flag byte indices
  // ----------------------------------------------------------------
  localparam int unsigned FIRST    = 32'(mfb_pkg::OFF_FLAG_FIRST);
  localparam int unsigned IDX_SIG  = 32'(mfb_pkg::OFF_SIGNAL_LOSS) - FIRST;
  localparam int unsigned IDX_FLT  = 32'(mfb_pkg::OFF_TX_FAULT) - FIRST;
  localparam int unsigned IDX_LOCK = 32'(mfb_pkg::OFF_LOCK_LOSS) - FIRST;
  localparam int unsigned IDX_TEMP = 32'(mfb_pkg::OFF_TEMP_FLAGS) - FIRST;
  localparam int unsigned IDX_VCC  = 32'(mfb_pkg::OFF_VCC_FLAGS) - FIRST;
  localparam int unsigned IDX_RXP  = 32'(mfb_pkg::OFF_RX_POW_CH12) - FIRST;
  localparam int unsigned IDX_BIAS = 32'(mfb_pkg::OFF_BIAS_CH12) - FIRST;
  localparam int unsigned IDX_TXP  = 32'(mfb_pkg::OFF_TX_POW_CH12) - FIRST;
  localparam int unsigned NUM      = mfb_pkg::NUM_FLAG_BYTES;
  localparam int unsigned INIT_BIT = mfb_pkg::INIT_DONE_BIT;

  mfb_pkg::mfb_state_t           q;
  mfb_pkg::mfb_state_t           d;
  logic [NUM-1:0][7:0]           cond;
  logic [NUM-1:0][7:0]           clr;
  logic [3:0]                    temp_lim;
  logic [3:0]                    vcc_lim;

  // ----------------------------------------------------------------
  // Reset image
  // ----------------------------------------------------------------

  function automatic mfb_pkg::mfb_state_t reset_state();
    mfb_pkg::mfb_state_t s;
    s                = '0;
    for (int i = 0; i < NUM; i++) begin
      s.flags[i] = mfb_pkg::FLAG_RESET;
    end
    s.init_pending   = 1'b1;
    s.data_not_ready = mfb_pkg::NOT_READY_RESET;
    s.temp           = mfb_pkg::MON_RESET;
    s.vcc            = mfb_pkg::MON_RESET;
    s.hold_sel       = mfb_pkg::MFB_HOLD_NONE;
    s.rd_data        = mfb_pkg::UNMAPPED_DATA;
    return s;
  endfunction : reset_state

  // ----------------------------------------------------------------
  // Module limit checks
  // ----------------------------------------------------------------

  // No comparison before the first valid sample, avoids false alarms
  mfb_limit_check #(
    .SIGNED_VALUE (1'b1)
  ) u_temp_check (
    .value_i  (q.temp),
    .thr_i    (temp_thr_i),
    .enable_i (!q.data_not_ready),
    .cond_o   (temp_lim)
  );

  mfb_limit_check #(
    .SIGNED_VALUE (1'b0)
  ) u_vcc_check (
    .value_i  (q.vcc),
    .thr_i    (vcc_thr_i),
    .enable_i (!q.data_not_ready),
    .cond_o   (vcc_lim)
  );

  // ----------------------------------------------------------------
  // Condition image of the flag field
  // ----------------------------------------------------------------

  always_comb begin
    cond = '0;
    cond[IDX_SIG][3:0]  = status_i.signal_absent;
    cond[IDX_FLT][3:0]  = status_i.laser_fault;
    cond[IDX_FLT][7:4]  = EQ_FAULT_SUPPORTED ?
                          status_i.equalizer_fault : 4'h0;
    cond[IDX_LOCK]      = {status_i.tx_lock_lost, status_i.rx_lock_lost};
    cond[IDX_TEMP][7:4] = temp_lim;
    cond[IDX_TEMP][INIT_BIT] = q.init_pending;
    cond[IDX_VCC][7:4]  = vcc_lim;
    // two channels per byte, lower channel high
    for (int p = 0; p < 2; p++) begin
      cond[IDX_RXP + p]  = {chan_cond_i.rx_power[2*p],
                            chan_cond_i.rx_power[2*p+1]};
      cond[IDX_BIAS + p] = {chan_cond_i.tx_bias[2*p],
                            chan_cond_i.tx_bias[2*p+1]};
      cond[IDX_TXP + p]  = {chan_cond_i.tx_power[2*p],
                            chan_cond_i.tx_power[2*p+1]};
    end
    // reserved and vendor bytes keep no conditions
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d              = q;
    clr            = '0;
    d.init_pending = 1'b0;
    d.rd_valid     = rd_req_i;

    // Monitor sample capture
    if (monitor_valid_i) begin
      d.temp           = temp_value_i;
      d.vcc            = vcc_value_i;
      d.data_not_ready = 1'b0;
    end

    if (rd_req_i) begin
      d.hold_sel = mfb_pkg::MFB_HOLD_NONE;
      unique case (rd_addr_i)
        mfb_pkg::OFF_TEMP_HIGH: begin
          d.rd_data  = q.temp[15:8];
          d.hold_sel = mfb_pkg::MFB_HOLD_TEMP;
          d.hold_lsb = q.temp[7:0];
        end
        mfb_pkg::OFF_TEMP_LOW: begin
          d.rd_data = (q.hold_sel == mfb_pkg::MFB_HOLD_TEMP) ?
                      q.hold_lsb : q.temp[7:0];
        end
        mfb_pkg::OFF_VCC_HIGH: begin
          d.rd_data  = q.vcc[15:8];
          d.hold_sel = mfb_pkg::MFB_HOLD_VCC;
          d.hold_lsb = q.vcc[7:0];
        end
        mfb_pkg::OFF_VCC_LOW: begin
          d.rd_data = (q.hold_sel == mfb_pkg::MFB_HOLD_VCC) ?
                      q.hold_lsb : q.vcc[7:0];
        end
        default: begin
          d.rd_data = mfb_pkg::UNMAPPED_DATA;
        end
      endcase
      for (int i = 0; i < NUM; i++) begin
        if (rd_addr_i == mfb_pkg::OFF_FLAG_FIRST + 7'(i)) begin
          d.rd_data = q.flags[i];
          clr[i]    = 8'hff;
        end
      end
    end

    // set wins over clear, a lasting condition re-latches
    for (int i = 0; i < NUM; i++) begin
      d.flags[i] = (q.flags[i] & ~clr[i]) | cond[i];
    end

    if (!module_reset_n_pin_i) begin
      d = reset_state();
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      q <= reset_state();
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign rd_data_o        = q.rd_data;
  assign rd_valid_o       = q.rd_valid;
  assign data_not_ready_o = q.data_not_ready;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  pin_reset_clear_a:
    assert property (!module_reset_n_pin_i |=> q.flags == '0)
    else $error("flags not cleared by module reset pin");

  condition_sets_a:
    assert property ((status_i.signal_absent[0] && module_reset_n_pin_i)
                     |=> q.flags[IDX_SIG][0])
    else $error("signal loss condition did not latch");

  flag_holds_a:
    assert property ((q.flags[IDX_FLT][0] && module_reset_n_pin_i &&
                      !(rd_req_i && rd_addr_i == mfb_pkg::OFF_TX_FAULT))
                     |=> q.flags[IDX_FLT][0])
    else $error("latched fault flag dropped without a read");

  read_clears_a:
    assert property ((rd_req_i && rd_addr_i == mfb_pkg::OFF_LOCK_LOSS &&
                      status_i.tx_lock_lost == 4'h0 &&
                      status_i.rx_lock_lost == 4'h0 && module_reset_n_pin_i)
                     |=> (q.flags[IDX_LOCK] == 8'h00 && rd_valid_o &&
                          rd_data_o == $past(q.flags[IDX_LOCK])))
    else $error("lock loss byte not returned and cleared by read");

  tx_loss_zero_a:
    assert property (q.flags[IDX_SIG][7:4] == 4'h0)
    else $error("unsupported transmit signal loss bits set");

  init_flag_a:
    assert property (($fell(reset_i) && module_reset_n_pin_i)
                     |=> q.flags[IDX_TEMP][INIT_BIT] ##1
                         (q.flags[IDX_TEMP][INIT_BIT] || rd_valid_o))
    else $error("initialization flag not raised after reset");

  temp_high_read_a:
    assert property ((rd_req_i && rd_addr_i == mfb_pkg::OFF_TEMP_HIGH &&
                      module_reset_n_pin_i)
                     |=> rd_data_o == $past(q.temp[15:8]))
    else $error("temperature high byte mismatch");

  msb_pair_a:
    assert property ((rd_req_i && rd_addr_i == mfb_pkg::OFF_VCC_HIGH &&
                      module_reset_n_pin_i) ##1
                     (rd_req_i && rd_addr_i == mfb_pkg::OFF_VCC_LOW &&
                      module_reset_n_pin_i)
                     |=> rd_data_o == $past(q.vcc[7:0], 2))
    else $error("supply low byte not taken with its high byte");

  not_ready_a:
    assert property ((data_not_ready_o && module_reset_n_pin_i)
                     |=> (data_not_ready_o == !$past(monitor_valid_i)))
    else $error("data not ready bit wrong around first sample");

  unmapped_zero_a:
    assert property ((rd_req_i && module_reset_n_pin_i &&
                      (rd_addr_i < mfb_pkg::OFF_FLAG_FIRST ||
                       (rd_addr_i > mfb_pkg::OFF_FLAG_LAST &&
                        rd_addr_i != mfb_pkg::OFF_TEMP_HIGH &&
                        rd_addr_i != mfb_pkg::OFF_TEMP_LOW &&
                        rd_addr_i != mfb_pkg::OFF_VCC_HIGH &&
                        rd_addr_i != mfb_pkg::OFF_VCC_LOW)))
                     |=> rd_data_o == mfb_pkg::UNMAPPED_DATA)
    else $error("address outside bank returned nonzero data");

  eq_fault_off_a:
    assert property (!EQ_FAULT_SUPPORTED |-> q.flags[IDX_FLT][7:4] == 4'h0)
    else $error("equalizer fault bits set while unsupported");

  tx_lock_map_a:
    assert property ((status_i.tx_lock_lost[3] && module_reset_n_pin_i)
                     |=> q.flags[IDX_LOCK][7])
    else $error("transmit lock loss of channel 4 not in bit 7");

  temp_alarm_a:
    assert property ((!q.data_not_ready && module_reset_n_pin_i &&
                      $signed(q.temp) > $signed(temp_thr_i.high_alarm))
                     |=> q.flags[IDX_TEMP][7])
    else $error("temperature high alarm not latched");

  vcc_alarm_a:
    assert property ((!q.data_not_ready && module_reset_n_pin_i &&
                      q.vcc < vcc_thr_i.low_alarm)
                     |=> q.flags[IDX_VCC][6])
    else $error("supply low alarm not latched");

  reserved_zero_a:
    assert property (q.flags[IDX_TEMP][3:1] == 3'h0 &&
                     q.flags[IDX_VCC][3:0] == 4'h0 &&
                     q.flags[IDX_VCC + 1] == 8'h00 &&
                     q.flags[NUM-1:IDX_TXP+2] == '0)
    else $error("reserved or vendor flag bits set");

  init_clear_a:
    assert property ((rd_req_i && rd_addr_i == mfb_pkg::OFF_TEMP_FLAGS &&
                      !q.init_pending && module_reset_n_pin_i)
                     |=> !q.flags[IDX_TEMP][INIT_BIT])
    else $error("initialization flag not cleared by its read");

  rx_power_map_a:
    assert property ((chan_cond_i.rx_power[1][3] && module_reset_n_pin_i)
                     |=> q.flags[IDX_RXP][3])
    else $error("channel 2 receive power alarm not in byte 9 bit 3");

  read_valid_a:
    assert property (module_reset_n_pin_i |=> rd_valid_o == $past(rd_req_i))
    else $error("read answer pulse does not follow its request");

  relatch_a:
    assert property ((rd_req_i && rd_addr_i == mfb_pkg::OFF_SIGNAL_LOSS &&
                      status_i.signal_absent[2] && module_reset_n_pin_i)
                     |=> q.flags[IDX_SIG][2])
    else $error("persistent signal loss lost by clearing read");

endmodule : mfb_flag_bank

//--- testbench/mfb_host_model.sv
/*
  Host side model of the serial engine that reads the flag bank one
  byte at a time.
  Assumes one clock shared with the bank; requests change at falling
  edges and the answer comes one cycle after the request is taken.
*/
module mfb_host_model (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] rd_data_i,
  input  wire logic       rd_valid_i,
  output logic            rd_req_o,
  output logic      [6:0] rd_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic timed_out;

  // Idle request, address parked away from the map
  initial begin
    rd_req_o  = 1'b0;
    rd_addr_o = 7'h7f;
    timed_out = 1'b0;
  end

  task automatic read_byte(input logic [6:0] addr, output logic [7:0] data);
    int n;
    @(negedge clk_sys_i);
    rd_req_o  = 1'b1;
    rd_addr_o = addr;
    @(negedge clk_sys_i);
    // Released address is inverted so stale values cannot match
    rd_req_o  = 1'b0;
    rd_addr_o = ~addr;
    n = 0;
    while (rd_valid_i !== 1'b1 && n < 4) begin
      @(negedge clk_sys_i);
      n++;
    end
    timed_out = (n == 4);
    data = rd_data_i;
  endtask : read_byte

  // high then low byte on back-to-back edges
  task automatic read_pair(input  logic [6:0] addr,
                           output logic [7:0] high,
                           output logic [7:0] low);
    @(negedge clk_sys_i);
    rd_req_o  = 1'b1;
    rd_addr_o = addr;
    @(negedge clk_sys_i);
    rd_addr_o = addr + 7'h01;
    high      = rd_data_i;
    timed_out = (rd_valid_i !== 1'b1);
    @(negedge clk_sys_i);
    rd_req_o  = 1'b0;
    rd_addr_o = ~addr;
    low       = rd_data_i;
    timed_out = timed_out || (rd_valid_i !== 1'b1);
  endtask : read_pair
endmodule : mfb_host_model

//--- testbench/tb_monitor_flag_bank.sv
/*
  Self-checking bench of the flag bank against an integer model.
  Assumes the package and bank core are compiled first.
*/
module tb_monitor_flag_bank;
  timeunit 1ns;
  timeprecision 1ps;

  logic                      clk_sys_i = 1'b0;
  logic                      reset_i   = 1'b1;
  logic                      pin_n     = 1'b1;
  mfb_pkg::mfb_chan_status_t stat      = '0;
  mfb_pkg::mfb_chan_cond_t   cond      = '0;
  logic [15:0]               temp_v    = 16'h0000;
  logic [15:0]               vcc_v     = 16'h0000;
  logic                      mon_vld   = 1'b0;
  mfb_pkg::mfb_thresh_t      temp_thr  = '0;
  mfb_pkg::mfb_thresh_t      vcc_thr   = '0;
  logic                      rd_req;
  logic [6:0]                rd_addr;
  logic [7:0]                rd_data;
  logic                      rd_valid;
  logic                      dnr;
  int                        fails     = 0;
  int                        checks    = 0;
  int                        exp_q [32];
  int                        keep_q [32];
  logic [15:0]               t_s, v_s;
  bit                        mon_ok;
  logic [7:0]                d;

  always #25 clk_sys_i = ~clk_sys_i;

  mfb_flag_bank i_mfb_flag_bank (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .module_reset_n_pin_i(pin_n), .status_i(stat), .chan_cond_i(cond),
    .temp_value_i(temp_v), .vcc_value_i(vcc_v), .monitor_valid_i(mon_vld),
    .temp_thr_i(temp_thr), .vcc_thr_i(vcc_thr), .rd_req_i(rd_req),
    .rd_addr_i(rd_addr), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
    .data_not_ready_o(dnr)
  );

  mfb_host_model i_mfb_host_model (
    .clk_sys_i(clk_sys_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
    .rd_req_o(rd_req), .rd_addr_o(rd_addr)
  );

  // ----------------------------------------------------------------
  // Model and checking
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  // Live condition levels, OR-ed into the latched image
  task automatic refresh();
    int t;
    for (int a = 0; a < 32; a++) keep_q[a] = 0;
    keep_q[3]  = stat.signal_absent;
    keep_q[4]  = stat.laser_fault;
    keep_q[5]  = {stat.tx_lock_lost, stat.rx_lock_lost};
    keep_q[9]  = {cond.rx_power[0], cond.rx_power[1]};
    keep_q[10] = {cond.rx_power[2], cond.rx_power[3]};
    keep_q[11] = {cond.tx_bias[0], cond.tx_bias[1]};
    keep_q[12] = {cond.tx_bias[2], cond.tx_bias[3]};
    keep_q[13] = {cond.tx_power[0], cond.tx_power[1]};
    keep_q[14] = {cond.tx_power[2], cond.tx_power[3]};
    // Signed temperature, unsigned supply, strict compares
    if (mon_ok) begin
      t = int'($signed(t_s));
      keep_q[6] = {t > int'($signed(temp_thr.high_alarm)),
                   t < int'($signed(temp_thr.low_alarm)),
                   t > int'($signed(temp_thr.high_warn)),
                   t < int'($signed(temp_thr.low_warn)), 4'h0};
      keep_q[7] = {v_s > vcc_thr.high_alarm, v_s < vcc_thr.low_alarm,
                   v_s > vcc_thr.high_warn, v_s < vcc_thr.low_warn, 4'h0};
    end
    keep_q[22] = t_s[15:8];
    keep_q[23] = t_s[7:0];
    keep_q[26] = v_s[15:8];
    keep_q[27] = v_s[7:0];
    for (int a = 0; a < 32; a++) exp_q[a] |= keep_q[a];
    // Monitor bytes follow the live sample, they never latch
    foreach (exp_q[a]) if (a inside {22, 23, 26, 27}) exp_q[a] = keep_q[a];
  endtask : refresh

  task automatic model_clear();
    for (int a = 0; a < 32; a++) exp_q[a] = 0;
    exp_q[6] = 1;
    mon_ok = 1'b0;
    t_s = 16'h0000;
    v_s = 16'h0000;
    refresh();
  endtask : model_clear

  task automatic rd_chk(input int a);
    i_mfb_host_model.read_byte(a[6:0], d);
    if (i_mfb_host_model.timed_out) begin
      fails++;
      complete_run();
    end else begin
      check($sformatf("byte %0d", a), d, exp_q[a][7:0]);
      exp_q[a] = keep_q[a];
    end
  endtask : rd_chk

  task automatic pulse_flags();
    @(negedge clk_sys_i);
    stat = 20'($urandom());
    cond = 48'({$urandom(), $urandom()});
    refresh();
    @(negedge clk_sys_i);
    stat = '0;
    cond = '0;
    refresh();
  endtask : pulse_flags

  // Sample lands between the high and the low read of a pair
  task automatic pair_chk(input int a);
    logic [7:0] hi;
    logic [7:0] lo;
    fork
      i_mfb_host_model.read_pair(a[6:0], hi, lo);
      begin
        @(negedge clk_sys_i);
        {mon_vld, temp_v, vcc_v} = {1'b1, ~t_s, ~v_s};
        @(negedge clk_sys_i);
        mon_vld = 1'b0;
      end
    join
    if (i_mfb_host_model.timed_out) begin
      fails++;
      complete_run();
    end else begin
      check($sformatf("pair %0d high", a), hi, exp_q[a][7:0]);
      check($sformatf("pair %0d low", a), lo, exp_q[a + 1][7:0]);
      {t_s, v_s} = {temp_v, vcc_v};
      refresh();
      rd_chk(a + 1);
    end
  endtask : pair_chk

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(56));
    model_clear();
    repeat (16) @(negedge clk_sys_i);
    reset_i = 1'b0;
    // Whole low map after reset, init flag once
    for (int a = 0; a < 32; a++) rd_chk(a);
    rd_chk(6);
    check("not ready", {7'h00, dnr}, 8'h01);
    $display("test reset_map done");
    // Random one-cycle conditions, latched then cleared by read
    repeat (4) begin
      pulse_flags();
      for (int a = 3; a < 15; a++) begin
        rd_chk(a);
        rd_chk(a);
      end
    end
    $display("test latch_clear done");
    // Condition held across the clearing read
    @(negedge clk_sys_i);
    stat.signal_absent = 4'h5;
    refresh();
    rd_chk(3);
    rd_chk(3);
    @(negedge clk_sys_i);
    stat = '0;
    refresh();
    rd_chk(3);
    rd_chk(3);
    $display("test persistent done");
    // Samples against thresholds, old sample meets new limits first
    repeat (6) begin
      @(negedge clk_sys_i);
      temp_thr = mfb_pkg::mfb_thresh_t'({$urandom(), $urandom()});
      vcc_thr  = mfb_pkg::mfb_thresh_t'({$urandom(), $urandom()});
      temp_v   = 16'($urandom());
      vcc_v    = 16'($urandom());
      mon_vld  = 1'b1;
      refresh();
      @(negedge clk_sys_i);
      mon_vld = 1'b0;
      {mon_ok, t_s, v_s} = {1'b1, temp_v, vcc_v};
      refresh();
      check("not ready", {7'h00, dnr}, 8'h00);
      foreach (keep_q[a]) if (a inside {22, 23, 26, 27, 6, 7}) begin
        rd_chk(a);
      end
    end
    $display("test monitors done");
    // New sample taken with the high byte read, low byte stays coherent
    pair_chk(22);
    pair_chk(26);
    $display("test pairs done");
    // Module reset pin wipes latched flags and monitors
    pulse_flags();
    @(negedge clk_sys_i);
    pin_n = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    pin_n = 1'b1;
    model_clear();
    check("not ready", {7'h00, dnr}, 8'h01);
    for (int a = 3; a < 28; a++) rd_chk(a);
    $display("test pin_reset done");
    complete_run();
  end
endmodule : tb_monitor_flag_bank
